// file: hdl/usc_ctrl_if.sv
// Interface: control state passed from the register file to the line driver
`timescale 1ns/1ps
`default_nettype none
interface usc_ctrl_if;
    logic                rts;
    logic                brk;
    logic                loop;
    logic                afc;
    logic                fifo_en;
    logic                sir;
    usc_pkg::usc_trig_e  trig;

    modport regs (output rts, brk, loop, afc, fifo_en, sir, trig);
    modport line (input rts, brk, loop, afc, fifo_en, sir, trig);
endinterface
`default_nettype wire

// file: hdl/usc_line_drive.sv
// Line driver: request-to-send, serial and infrared outputs with loopback paths
`timescale 1ns/1ps
`default_nettype none
module usc_line_drive #(
    parameter int DEPTH      = usc_pkg::FIFO_DEPTH,
    parameter int SIR_PERIOD = usc_pkg::SIR_BRK_PERIOD
) (
    // Clock and controller reset
    input  wire logic        hclk,
    input  wire logic        rst_n,
    // Control state
    usc_ctrl_if.line         ctl,
    // Datapath inputs
    input  wire logic [15:0] rx_level,
    input  wire logic        tx_serial,
    input  wire logic        ir_tx_n,
    // Line outputs
    output logic             rts_n,
    output logic             sout,
    output logic             sir_out_n,
    output logic             loop_cts,
    output logic             loop_rx
);

    logic [15:0] thr;
    logic        above;
    logic [7:0]  sir_cnt;
    logic        sir_brk;

    always_comb begin
        unique case (ctl.trig)
            usc_pkg::TRIG_ONE:       thr = 16'h0001;
            usc_pkg::TRIG_QUARTER:   thr = 16'(DEPTH / 4);
            usc_pkg::TRIG_HALF:      thr = 16'(DEPTH / 2);
            usc_pkg::TRIG_TWO_SHORT: thr = 16'(DEPTH - 2);
        endcase
    end

    assign above   = rx_level >= thr;
    assign sir_brk = ctl.sir && ctl.brk && !ctl.loop;

    ////////////////////////////////////////////////////////////////////////////
    // Outputs are held idle while the controller reset is on
    always_ff @(posedge hclk or negedge rst_n) begin
        if (!rst_n) begin
            rts_n    <= 1'b1;
            sout     <= 1'b1;
            loop_cts <= 1'b0;
            loop_rx  <= 1'b1;
        end else begin
            rts_n    <= ctl.loop || !ctl.rts ||
                        (ctl.afc && ctl.fifo_en && above);
            sout     <= ctl.loop || (!ctl.brk && tx_serial);
            loop_cts <= ctl.loop && ctl.rts;
            loop_rx  <= !ctl.loop || (!ctl.brk && tx_serial);
        end
    end

    // Break in infrared mode gives one low cycle per period
    always_ff @(posedge hclk or negedge rst_n) begin
        if (!rst_n) begin
            sir_cnt   <= 8'h00;
            sir_out_n <= 1'b1;
        end else begin
            if (!sir_brk || sir_cnt == 8'(SIR_PERIOD - 1)) begin
                sir_cnt <= 8'h00;
            end else begin
                sir_cnt <= sir_cnt + 8'h01;
            end
            if (ctl.loop) begin
                sir_out_n <= 1'b1;
            end else if (sir_brk) begin
                sir_out_n <= sir_cnt != 8'h00;
            end else begin
                sir_out_n <= ir_tx_n;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!rst_n);

    chk_rts_plain: assert property (!ctl.loop && !ctl.afc |=> rts_n == !$past(ctl.rts))
        else $error("rts_n does not follow the rts bit");
    chk_rts_throttle: assert property (!ctl.loop && ctl.afc && ctl.fifo_en && above |=> rts_n)
        else $error("rts_n not throttled above trigger");
    chk_rts_loop: assert property (ctl.loop |=> rts_n && loop_cts == $past(ctl.rts))
        else $error("loopback rts path wrong");
    chk_break_low: assert property (!ctl.loop && ctl.brk |=> !sout)
        else $error("sout not forced low by break");
    chk_break_loop: assert property (ctl.loop && ctl.brk |=> sout && !loop_rx)
        else $error("break not looped to receiver");
    chk_sir_pulse: assert property (sir_brk && sir_cnt == 8'h00 |=> !sir_out_n ##1 sir_out_n || !$past(sir_brk))
        else $error("infrared break pulse missing");

endmodule // usc_line_drive
`default_nettype wire

// file: hdl/usc_pkg.sv
// Package: addresses, field positions, reset values and counts of the shadow control block
package usc_pkg;

    // Register byte addresses
    localparam logic [31:0] ADDR_RX_LEVEL   = 32'h50001084;
    localparam logic [31:0] ADDR_FIFO_RST   = 32'h50001088;
    localparam logic [31:0] ADDR_RTS_SHADOW = 32'h5000108c;
    localparam logic [31:0] ADDR_BRK_SHADOW = 32'h50001090;
    localparam logic [31:0] ADDR_MODEM_CTRL = 32'h500010c0;
    localparam logic [31:0] ADDR_LINE_CTRL  = 32'h500010c4;
    localparam logic [31:0] ADDR_FIFO_CTRL  = 32'h500010c8;

    // Field positions
    localparam int FRST_TX_BIT   = 2;
    localparam int FRST_RX_BIT   = 1;
    localparam int FRST_UART_BIT = 0;
    localparam int SHADOW_BIT    = 0;
    localparam int MCR_RTS_BIT   = 1;
    localparam int MCR_LOOP_BIT  = 4;
    localparam int MCR_AFC_BIT   = 5;
    localparam int MCR_SIR_BIT   = 6;
    localparam int LCR_BRK_BIT   = 6;
    localparam int FCR_EN_BIT    = 0;
    localparam int FCR_RXC_BIT   = 1;
    localparam int FCR_TXC_BIT   = 2;
    localparam int FCR_TRIG_LO   = 6;
    localparam int FCR_TRIG_HI   = 7;

    // Values after reset
    localparam logic        RST_BIT   = 1'b0;
    localparam logic [31:0] RST_WORD  = 32'h00000000;

    // Counts
    localparam int FIFO_DEPTH     = 16;
    localparam int SIR_BRK_PERIOD = 16;

    // Receive trigger coding
    typedef enum logic [1:0] {
        TRIG_ONE       = 2'h0,
        TRIG_QUARTER   = 2'h1,
        TRIG_HALF      = 2'h2,
        TRIG_TWO_SHORT = 2'h3
    } usc_trig_e;

endpackage

// file: hdl/usc_shadow_regs.sv
// Top: shadow control registers on AHB-Lite with FIFO clears, controller reset and line control
`timescale 1ns/1ps
`default_nettype none

// Operation
// - The receive level register shows the current receive FIFO entry count straight from rx_fifo_level and has no reset value.
// - A one written to bit 2 of the reset register pulses the transmit FIFO clear for one cycle.
// - A one written to bit 1 of the reset register pulses the receive FIFO clear for one cycle.
// - The transmit clear behaves exactly like the transmit clear bit of the FIFO control register.
// - The receive clear behaves exactly like the receive clear bit of the FIFO control register.
// - A one written to bit 0 asserts the controller reset at once and releases it on the clock.
// - The controller reset clears the control state and the line logic of every domain.
// - The rts shadow bit and the rts bit of the modem control register are one flip-flop.
// - Outside loopback and without auto flow control rts_n is low exactly while the rts bit is set.
// - With auto flow control and FIFOs on, rts_n goes high while the receive level reaches the trigger.
// - In loopback rts_n stays high and the rts bit is returned on an internal input.
// - The break shadow bit and the break bit of the line control register are one flip-flop.
// - Outside loopback a set break bit holds the serial output low until it is cleared.
// - In infrared mode a set break bit pulses the infrared output continuously.
// - In loopback a set break bit is sent to the own receiver path instead of the pin.
// - The trigger code selects one entry, quarter, half or two short of full.
module usc_shadow_regs #(
    parameter int DEPTH      = usc_pkg::FIFO_DEPTH,
    parameter int SIR_PERIOD = usc_pkg::SIR_BRK_PERIOD
) (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic [2:0]  hsize,
    input  wire logic        hwrite,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // FIFO datapath
    input  wire logic [15:0] rx_fifo_level,
    input  wire logic        tx_serial,
    input  wire logic        ir_tx_n,
    output logic             tx_fifo_clear,
    output logic             rx_fifo_clear,
    // Controller reset
    output logic             uart_rst_n,
    // Line side
    output logic             rts_n,
    output logic             sout,
    output logic             sir_out_n,
    output logic             loop_cts,
    output logic             loop_rx
);

    usc_ctrl_if ctl ();

    logic        take;
    logic        dph_wr;
    logic [31:0] dph_addr;
    logic        wr_frst;
    logic        wr_srts;
    logic        wr_sbcr;
    logic        wr_mcr;
    logic        wr_lcr;
    logic        wr_fcr;
    logic        ur_req;
    logic        rst_src_n;
    logic        rst_meta;
    logic [31:0] rd_word;

    logic                next_rts;
    logic                next_brk;
    logic                next_loop;
    logic                next_afc;
    logic                next_sir;
    logic                next_fifo_en;
    usc_pkg::usc_trig_e  next_trig;

    ////////////////////////////////////////////////////////////////////////////
    // Bus address phase; only whole-word writes reach the registers
    assign take = hsel && hready && htrans[1];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_wr   <= 1'b0;
            dph_addr <= usc_pkg::RST_WORD;
        end else if (take) begin
            dph_wr   <= hwrite && hsize == 3'h2;
            dph_addr <= haddr;
        end else begin
            dph_wr   <= 1'b0;
        end
    end

    // Zero wait states, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Data phase write strobes
    assign wr_frst = dph_wr && dph_addr == usc_pkg::ADDR_FIFO_RST;
    assign wr_srts = dph_wr && dph_addr == usc_pkg::ADDR_RTS_SHADOW;
    assign wr_sbcr = dph_wr && dph_addr == usc_pkg::ADDR_BRK_SHADOW;
    assign wr_mcr  = dph_wr && dph_addr == usc_pkg::ADDR_MODEM_CTRL;
    assign wr_lcr  = dph_wr && dph_addr == usc_pkg::ADDR_LINE_CTRL;
    assign wr_fcr  = dph_wr && dph_addr == usc_pkg::ADDR_FIFO_CTRL;

    ////////////////////////////////////////////////////////////////////////////
    // Next control state; reads use it so a read right behind a write is fresh
    always_comb begin
        next_rts     = ctl.rts;
        next_brk     = ctl.brk;
        next_loop    = ctl.loop;
        next_afc     = ctl.afc;
        next_sir     = ctl.sir;
        next_fifo_en = ctl.fifo_en;
        next_trig    = ctl.trig;
        if (wr_mcr) begin
            next_rts  = hwdata[usc_pkg::MCR_RTS_BIT];
            next_loop = hwdata[usc_pkg::MCR_LOOP_BIT];
            next_afc  = hwdata[usc_pkg::MCR_AFC_BIT];
            next_sir  = hwdata[usc_pkg::MCR_SIR_BIT];
        end
        if (wr_srts) begin
            next_rts = hwdata[usc_pkg::SHADOW_BIT];
        end
        if (wr_lcr) begin
            next_brk = hwdata[usc_pkg::LCR_BRK_BIT];
        end
        if (wr_sbcr) begin
            next_brk = hwdata[usc_pkg::SHADOW_BIT];
        end
        if (wr_fcr) begin
            next_fifo_en = hwdata[usc_pkg::FCR_EN_BIT];
            next_trig    = usc_pkg::usc_trig_e'(hwdata[usc_pkg::FCR_TRIG_HI:usc_pkg::FCR_TRIG_LO]);
        end
    end

    // The controller reset also clears the control bits, as a real UART reset would
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctl.rts     <= usc_pkg::RST_BIT;
            ctl.brk     <= usc_pkg::RST_BIT;
            ctl.loop    <= usc_pkg::RST_BIT;
            ctl.afc     <= usc_pkg::RST_BIT;
            ctl.sir     <= usc_pkg::RST_BIT;
            ctl.fifo_en <= usc_pkg::RST_BIT;
            ctl.trig    <= usc_pkg::TRIG_ONE;
        end else if (!uart_rst_n) begin
            ctl.rts     <= usc_pkg::RST_BIT;
            ctl.brk     <= usc_pkg::RST_BIT;
            ctl.loop    <= usc_pkg::RST_BIT;
            ctl.afc     <= usc_pkg::RST_BIT;
            ctl.sir     <= usc_pkg::RST_BIT;
            ctl.fifo_en <= usc_pkg::RST_BIT;
            ctl.trig    <= usc_pkg::TRIG_ONE;
        end else begin
            ctl.rts     <= next_rts;
            ctl.brk     <= next_brk;
            ctl.loop    <= next_loop;
            ctl.afc     <= next_afc;
            ctl.sir     <= next_sir;
            ctl.fifo_en <= next_fifo_en;
            ctl.trig    <= next_trig;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Self-clearing FIFO clears; both registers drive the same pulse
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_fifo_clear <= 1'b0;
            rx_fifo_clear <= 1'b0;
        end else begin
            tx_fifo_clear <= (wr_frst && hwdata[usc_pkg::FRST_TX_BIT]) ||
                             (wr_fcr && hwdata[usc_pkg::FCR_TXC_BIT]);
            rx_fifo_clear <= (wr_frst && hwdata[usc_pkg::FRST_RX_BIT]) ||
                             (wr_fcr && hwdata[usc_pkg::FCR_RXC_BIT]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Controller reset: request is a flop so the async source is glitch free
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ur_req <= 1'b0;
        end else begin
            ur_req <= wr_frst && hwdata[usc_pkg::FRST_UART_BIT];
        end
    end

    assign rst_src_n = hresetn && !ur_req;

    always_ff @(posedge hclk or negedge rst_src_n) begin
        if (!rst_src_n) begin
            rst_meta   <= 1'b0;
            uart_rst_n <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            uart_rst_n <= rst_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read mux; write-only and unmapped words read zero
    always_comb begin
        rd_word = usc_pkg::RST_WORD;
        unique case (haddr)
            usc_pkg::ADDR_RX_LEVEL: begin
                rd_word[15:0] = rx_fifo_level;
            end
            usc_pkg::ADDR_RTS_SHADOW: begin
                rd_word[usc_pkg::SHADOW_BIT] = next_rts;
            end
            usc_pkg::ADDR_BRK_SHADOW: begin
                rd_word[usc_pkg::SHADOW_BIT] = next_brk;
            end
            usc_pkg::ADDR_MODEM_CTRL: begin
                rd_word[usc_pkg::MCR_RTS_BIT]  = next_rts;
                rd_word[usc_pkg::MCR_LOOP_BIT] = next_loop;
                rd_word[usc_pkg::MCR_AFC_BIT]  = next_afc;
                rd_word[usc_pkg::MCR_SIR_BIT]  = next_sir;
            end
            usc_pkg::ADDR_LINE_CTRL: begin
                rd_word[usc_pkg::LCR_BRK_BIT] = next_brk;
            end
            usc_pkg::ADDR_FIFO_CTRL: begin
                rd_word[usc_pkg::FCR_EN_BIT] = next_fifo_en;
                rd_word[usc_pkg::FCR_TRIG_HI:usc_pkg::FCR_TRIG_LO] = next_trig;
            end
            default: begin
                rd_word = usc_pkg::RST_WORD;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= usc_pkg::RST_WORD;
        end else if (take && !hwrite) begin
            hrdata <= rd_word;
        end else begin
            hrdata <= usc_pkg::RST_WORD;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Line driver runs under the controller reset
    usc_line_drive #(
        .DEPTH      (DEPTH),
        .SIR_PERIOD (SIR_PERIOD)
    ) u_line (
        .hclk      (hclk),
        .rst_n     (uart_rst_n),
        .ctl       (ctl.line),
        .rx_level  (rx_fifo_level),
        .tx_serial (tx_serial),
        .ir_tx_n   (ir_tx_n),
        .rts_n     (rts_n),
        .sout      (sout),
        .sir_out_n (sir_out_n),
        .loop_cts  (loop_cts),
        .loop_rx   (loop_rx)
    );

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    chk_level_read: assert property (
        take && !hwrite && haddr == usc_pkg::ADDR_RX_LEVEL
        |=> hrdata == {16'h0000, $past(rx_fifo_level)})
        else $error("receive level read wrong");
    chk_tx_clear: assert property (
        wr_frst && hwdata[usc_pkg::FRST_TX_BIT] |=> tx_fifo_clear ##1 (!tx_fifo_clear || $past(dph_wr)))
        else $error("transmit clear pulse wrong");
    chk_rx_clear: assert property (
        wr_frst && hwdata[usc_pkg::FRST_RX_BIT] |=> rx_fifo_clear ##1 (!rx_fifo_clear || $past(dph_wr)))
        else $error("receive clear pulse wrong");
    chk_fcr_tx_clear: assert property (
        wr_fcr && hwdata[usc_pkg::FCR_TXC_BIT] |=> tx_fifo_clear)
        else $error("control transmit clear missing");
    chk_fcr_rx_clear: assert property (
        wr_fcr && hwdata[usc_pkg::FCR_RXC_BIT] |=> rx_fifo_clear)
        else $error("control receive clear missing");
    chk_uart_reset: assert property (
        ur_req |-> !uart_rst_n ##1 (!uart_rst_n [*2]) ##1 (uart_rst_n || $past(ur_req, 2)))
        else $error("controller reset timing wrong");
    chk_rts_mirror: assert property (
        wr_srts && uart_rst_n |=> ctl.rts == $past(hwdata[usc_pkg::SHADOW_BIT]))
        else $error("rts shadow not mirrored");
    chk_brk_mirror: assert property (
        wr_lcr && !wr_sbcr && uart_rst_n |=> ctl.brk == $past(hwdata[usc_pkg::LCR_BRK_BIT]))
        else $error("break bit not mirrored");
    chk_reserved_zero: assert property (
        take && !hwrite && (haddr == usc_pkg::ADDR_RTS_SHADOW || haddr == usc_pkg::ADDR_FIFO_RST)
        |=> hrdata[31:1] == 31'h00000000)
        else $error("reserved bits not zero");

endmodule // usc_shadow_regs
`default_nettype wire

// file: test/tb_top.sv
// Testbench: register bus, FIFO clears, controller reset and line control scenarios
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int SIRP = 8;
    logic             hclk, hresetn, hsel, hwrite, tx_serial, ir_tx_n;
    logic [31:0]      haddr, hwdata, rd;
    logic [1:0]       htrans;
    logic [2:0]       hsize;
    logic [15:0]      rx_fifo_level;
    wire logic        hreadyout, hresp, tx_fifo_clear, rx_fifo_clear, uart_rst_n;
    wire logic        rts_n, sout, sir_out_n, loop_cts, loop_rx, rts_seen;
    wire logic [31:0] hrdata;
    wire logic [7:0]  brk_len;
    int               n_fail, total_checks;

    usc_shadow_regs #(.DEPTH(16), .SIR_PERIOD(SIRP)) u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hsize(hsize), .hwrite(hwrite), .hready(hreadyout), .hwdata(hwdata),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .rx_fifo_level(rx_fifo_level), .tx_serial(tx_serial), .ir_tx_n(ir_tx_n),
        .tx_fifo_clear(tx_fifo_clear), .rx_fifo_clear(rx_fifo_clear),
        .uart_rst_n(uart_rst_n), .rts_n(rts_n), .sout(sout), .sir_out_n(sir_out_n),
        .loop_cts(loop_cts), .loop_rx(loop_rx));

    usc_modem_model u_modem (.hclk(hclk), .rts_n(rts_n), .sout(sout),
        .rts_seen(rts_seen), .brk_len(brk_len));

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Ready and read data are taken as they stand at the rising edge
    task automatic wait_ready;
        logic ok;
        ok = 1'b0;
        for (int i = 0; i < 50 && !ok; i++) begin
            @(posedge hclk);
            ok = (hreadyout === 1'b1);
            rd = hrdata;
        end
        if (!ok) begin
            n_fail++;
            $display("MISMATCH t=%0t bus ready timeout", $time);
            report_and_stop();
        end
    endtask

    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= 3'h2;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
    endtask

    task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
        chk(32'(hresp), 32'h0);
    endtask

    task automatic settle;
        repeat (2) @(negedge hclk);
    endtask

    // A clear write must give exactly one cycle of pulse on the expected lines
    task automatic clr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] exp);
        bus(1'b1, a, d);
        @(negedge hclk);
        chk(32'({tx_fifo_clear, rx_fifo_clear}), 32'(exp));
        @(negedge hclk);
        chk(32'({tx_fifo_clear, rx_fifo_clear}), 32'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_vals;
        @(posedge hclk);
        rx_fifo_level <= 16'h000d;
        rdchk(usc_pkg::ADDR_RX_LEVEL, 32'h0000000d);
        rdchk(usc_pkg::ADDR_FIFO_RST, 32'h0);
        rdchk(usc_pkg::ADDR_RTS_SHADOW, 32'h0);
        rdchk(usc_pkg::ADDR_BRK_SHADOW, 32'h0);
        rdchk(32'h50001094, 32'h0);
    endtask

    task automatic t_clears;
        clr(usc_pkg::ADDR_FIFO_RST, 32'h00000006, 2'h3);
        clr(usc_pkg::ADDR_FIFO_RST, 32'h00000004, 2'h2);
        clr(usc_pkg::ADDR_FIFO_RST, 32'hfffffff2, 2'h1);
        clr(usc_pkg::ADDR_FIFO_CTRL, 32'h00000004, 2'h2);
        clr(usc_pkg::ADDR_FIFO_CTRL, 32'h00000002, 2'h1);
    endtask

    task automatic t_rts;
        bus(1'b1, usc_pkg::ADDR_RTS_SHADOW, 32'hffffffff);
        rdchk(usc_pkg::ADDR_RTS_SHADOW, 32'h1);
        rdchk(usc_pkg::ADDR_MODEM_CTRL, 32'h2);
        settle();
        chk(32'(rts_n), 32'h0);
        chk(32'(rts_seen), 32'h1);
        bus(1'b1, usc_pkg::ADDR_MODEM_CTRL, 32'h0);
        rdchk(usc_pkg::ADDR_RTS_SHADOW, 32'h0);
        settle();
        chk(32'(rts_n), 32'h1);
    endtask

    // Each trigger code: one below the threshold keeps rts, the threshold drops it
    task automatic t_afc;
        int thr[4] = '{1, 4, 8, 14};
        bus(1'b1, usc_pkg::ADDR_MODEM_CTRL, 32'h22);
        for (int k = 0; k < 4; k++) begin
            bus(1'b1, usc_pkg::ADDR_FIFO_CTRL, (32'(k) << 6) | 32'h1);
            @(posedge hclk);
            rx_fifo_level <= 16'(thr[k] - 1);
            settle();
            chk(32'(rts_n), 32'h0);
            @(posedge hclk);
            rx_fifo_level <= 16'(thr[k]);
            settle();
            chk(32'(rts_n), 32'h1);
        end
        bus(1'b1, usc_pkg::ADDR_FIFO_CTRL, 32'h0);
        settle();
        chk(32'(rts_n), 32'h0);
    endtask

    task automatic t_brk;
        @(posedge hclk);
        tx_serial <= 1'b0;
        settle();
        chk(32'({sout, loop_rx}), 32'h1);
        @(posedge hclk);
        tx_serial <= 1'b1;
        bus(1'b1, usc_pkg::ADDR_BRK_SHADOW, 32'h1);
        rdchk(usc_pkg::ADDR_LINE_CTRL, 32'h40);
        settle();
        chk(32'(sout), 32'h0);
        repeat (6) @(negedge hclk);
        chk(32'(brk_len >= 8'h06), 32'h1);
        bus(1'b1, usc_pkg::ADDR_MODEM_CTRL, 32'h12);
        settle();
        chk(32'({rts_n, loop_cts, sout, loop_rx}), 32'he);
        bus(1'b1, usc_pkg::ADDR_LINE_CTRL, 32'h0);
        rdchk(usc_pkg::ADDR_BRK_SHADOW, 32'h0);
        settle();
        chk(32'(loop_rx), 32'h1);
        bus(1'b1, usc_pkg::ADDR_MODEM_CTRL, 32'h0);
    endtask

    task automatic t_sir;
        int lows;
        lows = 0;
        bus(1'b1, usc_pkg::ADDR_MODEM_CTRL, 32'h40);
        @(posedge hclk);
        ir_tx_n <= 1'b0;
        settle();
        chk(32'(sir_out_n), 32'h0);
        @(posedge hclk);
        ir_tx_n <= 1'b1;
        bus(1'b1, usc_pkg::ADDR_BRK_SHADOW, 32'h1);
        settle();
        for (int i = 0; i < 4 * SIRP; i++) begin
            @(negedge hclk);
            lows += (sir_out_n === 1'b0);
        end
        chk(32'(lows), 32'h4);
    endtask

    // Controller state set beforehand must be gone once the reset is released
    task automatic t_urst;
        bus(1'b1, usc_pkg::ADDR_RTS_SHADOW, 32'h1);
        bus(1'b1, usc_pkg::ADDR_FIFO_RST, 32'h1);
        @(negedge hclk);
        chk(32'(uart_rst_n), 32'h0);
        repeat (2) @(negedge hclk);
        chk(32'(uart_rst_n), 32'h0);
        @(negedge hclk);
        chk(32'(uart_rst_n), 32'h1);
        rdchk(usc_pkg::ADDR_RTS_SHADOW, 32'h0);
        rdchk(usc_pkg::ADDR_BRK_SHADOW, 32'h0);
        chk(32'({rts_n, sout, sir_out_n}), 32'h7);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        n_fail = 0;
        total_checks = 0;
        hresetn = 1'b0;
        hsel = 1'b0;
        hwrite = 1'b0;
        haddr = 32'h0;
        hwdata = 32'h0;
        htrans = 2'h0;
        hsize = 3'h2;
        rx_fifo_level = 16'h0;
        tx_serial = 1'b1;
        ir_tx_n = 1'b1;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (3) @(posedge hclk);
        t_reset_vals();
        t_clears();
        t_rts();
        t_afc();
        t_brk();
        t_sir();
        t_urst();
        report_and_stop();
    end
endmodule // tb_top
`default_nettype wire

// file: test/usc_modem_model.sv
// Modem side model: watches request-to-send and measures breaks on the serial line
`timescale 1ns/1ps
`default_nettype none
module usc_modem_model (
    // Clock
    input  wire logic       hclk,
    // Line from the block
    input  wire logic       rts_n,
    input  wire logic       sout,
    // Observations
    output logic            rts_seen,
    output logic [7:0]      brk_len
);
    always_ff @(posedge hclk) begin
        rts_seen <= ~rts_n;
    end

    // Saturate so that a long break never wraps back to a short one
    always_ff @(posedge hclk) begin
        if (sout) begin
            brk_len <= 8'h00;
        end else if (brk_len != 8'hff) begin
            brk_len <= brk_len + 8'h01;
        end
    end
endmodule // usc_modem_model
`default_nettype wire
